// ==== design/crst_pkg.sv ====
// Purpose: constants and carrier types for the chip reset sequencer
// Assumes: 125 MHz system clock; fuse inputs are static while the chip runs
// Notes: the power-up delay count is large, so the top module exposes it as a parameter
//
// Functional notes
// [RL1] a supply-rise event from the detector puts the chip into reset
// [RL2] master clear input low requests reset; the outside drives it low
// [RL3] a watchdog time-out puts the chip into reset
// [RL4] reset stays asserted the whole time master clear is low
// [RL5] after master clear rises, reset holds until the power-up delay ends
// [RL6] after master clear rises, reset holds until the oscillator start-up delay ends
// [RL7] program counter is forced to zero while reset is applied
// [RL8] oscillator buffer is enabled on reset, restarting it from power-down
// [RL9] watchdog count and prescaler are cleared whenever reset is applied
// [RL10] the four-phase clock generator holds the first phase during reset
// [RL11] with external execution, reset drives latch enable low and both strobes high
// [RL12] every pin of ports B, C, D and E is an input during reset
// [RL13] port B weak pull-ups are switched on during reset
// [RL14] port A pins 2 and 3 go high impedance during reset
// [RL15] power-up delay of nominally 80 ms runs on power-up only
// [RL16] watchdog is disabled only by the configuration fuse, never by software
// [RL17] power-down ends on external reset, watchdog time-out or enabled interrupt
// [RL18] oscillator start-up delay counts 1024 oscillator periods in ten bits; the counter here is 11 bits wide
// [RL19] the power-up delay starts at the rising edge of master clear
// [RL20] no oscillator start-up delay in RC or external clock mode
// [RL21] on wake-up the start-up delay counts from the wake-up event
// [RL22] all sources merge into one reset, released only when all holds clear together
// [RL23] reset release is synchronous so every register leaves reset on one edge

package crst_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_FREQ_KHZ = 125000;
  localparam int unsigned POWER_UP_DELAY_TIMER_TIME_MS = 80;
  localparam int unsigned POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned OST_PERIODS = 1024;
  localparam int unsigned OST_WIDTH = 10;
  localparam int unsigned WDT_PRE_WIDTH = 8;
  localparam int unsigned WDT_CNT_WIDTH = 8;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [7:0] PORT_OE_RESET = 8'h00;

  // ==========================================================================
  // oscillator fuse codes
  localparam logic [1:0] OSC_LF = 2'h0;
  localparam logic [1:0] OSC_RC = 2'h1;
  localparam logic [1:0] OSC_XT = 2'h2;
  localparam logic [1:0] OSC_EC = 2'h3;

  typedef enum logic [2:0] {
    CRST_HOLD,
    CRST_TIMING,
    CRST_RUN,
    CRST_SLEEP,
    CRST_WAKE
  } crst_state_t;

  typedef enum logic [1:0] {
    FIRST_PHASE,
    SECOND_PHASE,
    THIRD_PHASE,
    FOURTH_PHASE
  } crst_phase_t;

  typedef struct packed {
    logic addr_latch_enable;
    logic read_strobe_n;
    logic write_strobe_n;
  } crst_bus_t;

  typedef struct packed {
    logic [7:0] port_b_oe;
    logic [7:0] port_c_oe;
    logic [7:0] port_d_oe;
    logic [7:0] port_e_oe;
    logic port_b_pullup_en;
    logic port_a_pin2_oe;
    logic port_a_pin3_oe;
  } crst_port_t;

  // crystal modes need the start-up delay; rc and external clock do not
  function automatic logic crst_needs_ost(input logic [1:0] mode);
    crst_needs_ost = (mode == OSC_XT) || (mode == OSC_LF); // RL20
  endfunction

endpackage

// ==== design/crst_timeout.sv ====
// Purpose: one-shot time-out counter for the reset sequencer delays
// Assumes: tick_i is a one-cycle pulse per counted period
// Notes: done_o stays high until clear_i

`timescale 1ns/100ps

module crst_timeout #(
  parameter int unsigned LIMIT = 1024
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic tick_i,
  output logic done_o
);

  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  logic [W-1:0] count;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
      done_o <= 1'b0;
    end else if (clear_i) begin
      count <= '0;
      done_o <= 1'b0;
    end else if (tick_i && !done_o) begin
      if (count == LAST) begin
        done_o <= 1'b1;
      end else begin
        count <= count + W'(1);
      end
    end
  end

endmodule

// ==== design/crst_sequencer.sv ====
// Purpose: chip-level reset sequencer merging power-on, master clear and watchdog
// Assumes: all inputs synchronous to clk_i; osc_tick_i pulses once per oscillator period
// Notes: core_rst_n_o is the merged reset; forced pin states are applied while it is low

`timescale 1ns/100ps

module crst_sequencer
  import crst_pkg::*;
#(
  parameter int unsigned POWER_UP_DELAY_TIMER_COUNT = POWER_UP_DELAY_TIMER_CYCLES,
  parameter int unsigned OST_COUNT = OST_PERIODS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic por_event_i,
  input wire logic master_clear_n_i,
  input wire logic [1:0] osc_mode_i,
  input wire logic osc_tick_i,
  input wire logic wdt_fuse_en_i,
  input wire logic wdt_tick_i,
  input wire logic wdt_clear_i,
  input wire logic sleep_req_i,
  input wire logic wake_irq_i,
  input wire logic ext_exec_i,
  input wire crst_bus_t core_bus_i,
  input wire crst_port_t core_port_i,
  output logic core_rst_n_o,
  output logic core_run_o,
  output logic pc_force_o,
  output logic [15:0] pc_value_o,
  output logic osc_buf_en_o,
  output crst_phase_t phase_o,
  output logic wdt_timeout_o,
  output logic power_down_o,
  output crst_bus_t bus_o,
  output crst_port_t port_o
);

  // ==========================================================================
  // state and merged reset
  crst_state_t state;
  crst_state_t next_state;
  logic next_reset;
  logic hold_src;
  logic power_up_delay_timer_needed;
  logic ost_needed;
  logic power_up_delay_timer_done;
  logic ost_done;
  logic wdt_timeout;
  logic ost_ok;
  logic power_up_delay_timer_ok;
  logic [WDT_PRE_WIDTH-1:0] wdt_pre;
  logic [WDT_CNT_WIDTH-1:0] wdt_cnt;

  // every source funnels into one hold term
  assign hold_src = por_event_i || !master_clear_n_i || wdt_timeout; // RL1 RL2 RL3 RL22

  assign power_up_delay_timer_ok = !power_up_delay_timer_needed || power_up_delay_timer_done; // RL5
  assign ost_ok = !ost_needed || !crst_needs_ost(osc_mode_i) || ost_done; // RL6 RL20

  always_comb begin
    next_state = state;
    unique case (state)
      CRST_HOLD: begin
        // held for as long as master clear is low
        if (!hold_src) begin // RL4
          next_state = CRST_TIMING;
        end
      end
      CRST_TIMING: begin
        if (hold_src) begin
          next_state = CRST_HOLD;
        end else if (power_up_delay_timer_ok && ost_ok) begin // RL22
          next_state = CRST_RUN;
        end
      end
      CRST_RUN: begin
        if (hold_src) begin
          next_state = CRST_HOLD;
        end else if (sleep_req_i) begin
          next_state = CRST_SLEEP;
        end
      end
      CRST_SLEEP: begin
        if (hold_src) begin // RL17
          next_state = CRST_HOLD;
        end else if (wake_irq_i) begin // RL17
          next_state = crst_needs_ost(osc_mode_i) ? CRST_WAKE : CRST_RUN; // RL20
        end
      end
      CRST_WAKE: begin
        if (hold_src) begin
          next_state = CRST_HOLD;
        end else if (ost_done) begin // RL21
          next_state = CRST_RUN;
        end
      end
    endcase
  end

  assign next_reset = (next_state == CRST_HOLD) || (next_state == CRST_TIMING);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= CRST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // registered release keeps every consumer leaving reset on one edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_rst_n_o <= 1'b0;
      core_run_o <= 1'b0;
      power_down_o <= 1'b0;
    end else begin
      core_rst_n_o <= !next_reset; // RL23
      core_run_o <= (next_state == CRST_RUN);
      power_down_o <= (next_state == CRST_SLEEP);
    end
  end

  // ==========================================================================
  // delay bookkeeping
  // power-up delay only after a supply rise; a later master clear pulse skips it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_up_delay_timer_needed <= 1'b1;
    end else if (por_event_i) begin
      power_up_delay_timer_needed <= 1'b1; // RL15
    end else if (state == CRST_TIMING && next_state == CRST_RUN) begin
      power_up_delay_timer_needed <= 1'b0;
    end
  end

  // start-up delay on power-up and whenever a reset restarts a stopped oscillator
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ost_needed <= 1'b1;
    end else if (por_event_i || (state == CRST_SLEEP && hold_src)) begin
      ost_needed <= 1'b1; // RL8
    end else if (state == CRST_TIMING && next_state == CRST_RUN) begin
      ost_needed <= 1'b0;
    end
  end

  // both timers stay cleared while master clear is low and start at its rise
  crst_timeout #(
    .LIMIT(POWER_UP_DELAY_TIMER_COUNT)
  ) u_power_up_delay_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(state == CRST_HOLD), // RL19
    .tick_i(1'b1),
    .done_o(power_up_delay_timer_done)
  );

  // cleared in power-down so a wake-up counts from the wake event
  crst_timeout #(
    .LIMIT(OST_COUNT)
  ) u_ost (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(state == CRST_HOLD || state == CRST_SLEEP), // RL18 RL21
    .tick_i(osc_tick_i),
    .done_o(ost_done)
  );

  // ==========================================================================
  // watchdog
  // the fuse is the only enable; software can only restart the count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_pre <= '0;
      wdt_cnt <= '0;
    end else if (next_reset || wdt_clear_i || (state == CRST_RUN && sleep_req_i)) begin
      wdt_pre <= '0; // RL9
      wdt_cnt <= '0; // RL9
    end else if (wdt_fuse_en_i && wdt_tick_i) begin // RL16
      wdt_pre <= wdt_pre + WDT_PRE_WIDTH'(1);
      if (&wdt_pre) begin
        wdt_cnt <= wdt_cnt + WDT_CNT_WIDTH'(1);
      end
    end
  end

  // keeps running in power-down so a time-out can wake the chip
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_timeout <= 1'b0;
    end else begin
      wdt_timeout <= wdt_fuse_en_i && wdt_tick_i && (&wdt_pre) && (&wdt_cnt) &&
                     !next_reset && !wdt_clear_i; // RL3 RL16
    end
  end

  assign wdt_timeout_o = wdt_timeout;

  // ==========================================================================
  // program counter, oscillator and phase generator
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_force_o <= 1'b1;
      pc_value_o <= RESET_VECTOR;
    end else begin
      pc_force_o <= next_reset; // RL7
      pc_value_o <= RESET_VECTOR; // RL7
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_buf_en_o <= 1'b1;
    end else begin
      osc_buf_en_o <= next_reset || (next_state != CRST_SLEEP); // RL8
    end
  end

  // clocks are frozen in power-down and during the wake-up delay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_o <= FIRST_PHASE;
    end else if (next_reset) begin
      phase_o <= FIRST_PHASE; // RL10
    end else if (state == CRST_RUN && next_state == CRST_RUN) begin
      unique case (phase_o)
        FIRST_PHASE: phase_o <= SECOND_PHASE;
        SECOND_PHASE: phase_o <= THIRD_PHASE;
        THIRD_PHASE: phase_o <= FOURTH_PHASE;
        FOURTH_PHASE: phase_o <= FIRST_PHASE;
      endcase
    end
  end

  // ==========================================================================
  // external bus strobes and port pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_o.addr_latch_enable <= 1'b0;
      bus_o.read_strobe_n <= 1'b1;
      bus_o.write_strobe_n <= 1'b1;
    end else if (next_reset && ext_exec_i) begin
      bus_o.addr_latch_enable <= 1'b0; // RL11
      bus_o.read_strobe_n <= 1'b1; // RL11
      bus_o.write_strobe_n <= 1'b1; // RL11
    end else begin
      bus_o <= core_bus_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_o.port_b_oe <= PORT_OE_RESET;
      port_o.port_c_oe <= PORT_OE_RESET;
      port_o.port_d_oe <= PORT_OE_RESET;
      port_o.port_e_oe <= PORT_OE_RESET;
      port_o.port_b_pullup_en <= 1'b1;
      port_o.port_a_pin2_oe <= 1'b0;
      port_o.port_a_pin3_oe <= 1'b0;
    end else if (next_reset) begin
      port_o.port_b_oe <= PORT_OE_RESET; // RL12
      port_o.port_c_oe <= PORT_OE_RESET; // RL12
      port_o.port_d_oe <= PORT_OE_RESET; // RL12
      port_o.port_e_oe <= PORT_OE_RESET; // RL12
      port_o.port_b_pullup_en <= 1'b1; // RL13
      port_o.port_a_pin2_oe <= 1'b0; // RL14
      port_o.port_a_pin3_oe <= 1'b0; // RL14
    end else begin
      port_o <= core_port_i;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_leave_timing;
    state == CRST_TIMING ##1 state == CRST_RUN;
  endsequence

  sequence s_in_reset;
    !core_rst_n_o;
  endsequence

  property p_por_reset;
    por_event_i |=> s_in_reset;
  endproperty
  a_por_reset: assert property (p_por_reset) else $error("no reset after supply rise"); // RL1

  property p_master_clear_n_hold;
    !master_clear_n_i |=> s_in_reset ##0 state == CRST_HOLD;
  endproperty
  a_master_clear_n_hold: assert property (p_master_clear_n_hold) else $error("master clear low not held"); // RL4

  property p_wdt_reset;
    wdt_timeout |=> s_in_reset;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog time-out no reset"); // RL3

  property p_power_up_delay_timer_release;
    s_leave_timing |-> $past(power_up_delay_timer_ok);
  endproperty
  a_power_up_delay_timer_release: assert property (p_power_up_delay_timer_release) else $error("release before power-up delay"); // RL5

  property p_ost_release;
    s_leave_timing |-> $past(ost_ok);
  endproperty
  a_ost_release: assert property (p_ost_release) else $error("release before start-up delay"); // RL6

  property p_pc_zero;
    s_in_reset |-> pc_force_o && pc_value_o == RESET_VECTOR;
  endproperty
  a_pc_zero: assert property (p_pc_zero) else $error("pc not forced in reset"); // RL7

  property p_osc_on;
    s_in_reset |-> osc_buf_en_o;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator off in reset"); // RL8

  property p_wdt_clear;
    s_in_reset |-> wdt_pre == '0 && wdt_cnt == '0;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared"); // RL9

  property p_phase_hold;
    s_in_reset |-> phase_o == FIRST_PHASE;
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase not first in reset"); // RL10

  property p_bus_idle;
    s_in_reset ##0 $past(ext_exec_i) |->
      !bus_o.addr_latch_enable && bus_o.read_strobe_n && bus_o.write_strobe_n;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("bus strobes active in reset"); // RL11

  property p_ports_safe;
    s_in_reset |-> port_o.port_b_oe == '0 && port_o.port_c_oe == '0 &&
      port_o.port_d_oe == '0 && port_o.port_e_oe == '0 &&
      port_o.port_b_pullup_en && !port_o.port_a_pin2_oe && !port_o.port_a_pin3_oe;
  endproperty
  a_ports_safe: assert property (p_ports_safe) else $error("port pins not safe in reset"); // RL12

  property p_wdt_fuse;
    !wdt_fuse_en_i |=> !wdt_timeout;
  endproperty
  a_wdt_fuse: assert property (p_wdt_fuse) else $error("watchdog fired while fused off"); // RL16

  property p_wake;
    state == CRST_SLEEP && wake_irq_i && !hold_src |=> state inside {CRST_WAKE, CRST_RUN};
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake"); // RL17

  property p_no_ost_rc;
    !crst_needs_ost(osc_mode_i) |-> state != CRST_WAKE;
  endproperty
  a_no_ost_rc: assert property (p_no_ost_rc) else $error("start-up delay in rc mode"); // RL20

  property p_sync_release;
    $rose(core_rst_n_o) |-> core_run_o && phase_o == FIRST_PHASE && !pc_force_o;
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("outputs left reset apart"); // RL23

endmodule

// ==== testbench/crst_ext_model.sv ====
// Purpose: outside party of the reset sequencer: master clear pin and oscillator
// Assumes: clk_i is the system clock; the pin follows hold_low_i at once
// Notes: oscillator ticks stand still while osc_run_i is low

`timescale 1ns/100ps

module crst_ext_model #(
  parameter int unsigned TICK_DIV = 4
) (
  input wire logic clk_i,
  input wire logic hold_low_i,
  input wire logic osc_run_i,
  output logic master_clear_n_o,
  output logic osc_tick_o
);
  int unsigned div = 0;

  // ==========================================================================
  // master clear pin
  // pulled up; only an explicit request takes it low
  assign master_clear_n_o = !hold_low_i;

  // ==========================================================================
  // oscillator
  // one tick every TICK_DIV clocks, slower than the system clock as a crystal is
  always @(negedge clk_i) begin
    if (osc_run_i && div == TICK_DIV - 1) begin
      osc_tick_o <= 1'b1;
      div <= 0;
    end else begin
      osc_tick_o <= 1'b0;
      div <= osc_run_i ? div + 1 : 0;
    end
  end
endmodule

// ==== testbench/crst_sequencer_test.sv ====
// Purpose: self-checking bench for the chip reset sequencer
// Assumes: shortened power-up and start-up counts; crystal mode unless stated
// Notes: inputs change on the falling edge, outputs are sampled there

`timescale 1ns/100ps

module crst_sequencer_test;
  import crst_pkg::*;
  localparam int unsigned POWER_UP_DELAY_TIMER = 20;
  localparam int unsigned OSC_STARTUP_TIMER = 8;
  localparam int unsigned DIV = 4;
  localparam logic [34:0] PORT_SAFE = 35'h0_0000_0004;
  localparam logic [34:0] PORT_ALL = 35'h7_ffff_ffff;

  logic clk_i = 1'b0, rst_n_i = 1'b0, por_event_i = 1'b0, wdt_tick_i = 1'b0;
  logic sleep_req_i = 1'b0, wake_irq_i = 1'b0, hold_low = 1'b1, osc_run = 1'b1;
  logic [1:0] osc_mode_i = OSC_XT;
  crst_bus_t core_bus_i = 3'h4;
  crst_port_t core_port_i = PORT_ALL;
  logic master_clear_n, osc_tick_i, core_rst_n_o, core_run_o, pc_force_o;
  logic osc_buf_en_o, wdt_timeout_o, power_down_o;
  logic [15:0] pc_value_o;
  crst_phase_t phase_o;
  crst_bus_t bus_o;
  crst_port_t port_o;
  int miscompares = 0;
  int n_checks = 0;

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  crst_ext_model #(.TICK_DIV(DIV)) crst_ext_model_inst (
    .clk_i(clk_i), .hold_low_i(hold_low), .osc_run_i(osc_run),
    .master_clear_n_o(master_clear_n), .osc_tick_o(osc_tick_i)
  );

  crst_sequencer #(.POWER_UP_DELAY_TIMER_COUNT(POWER_UP_DELAY_TIMER), .OST_COUNT(OSC_STARTUP_TIMER)) crst_sequencer_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .por_event_i(por_event_i),
    .master_clear_n_i(master_clear_n), .osc_mode_i(osc_mode_i), .osc_tick_i(osc_tick_i),
    .wdt_fuse_en_i(1'b1), .wdt_tick_i(wdt_tick_i), .wdt_clear_i(1'b0),
    .sleep_req_i(sleep_req_i), .wake_irq_i(wake_irq_i), .ext_exec_i(1'b1),
    .core_bus_i(core_bus_i), .core_port_i(core_port_i), .core_rst_n_o(core_rst_n_o),
    .core_run_o(core_run_o), .pc_force_o(pc_force_o), .pc_value_o(pc_value_o),
    .osc_buf_en_o(osc_buf_en_o), .phase_o(phase_o), .wdt_timeout_o(wdt_timeout_o),
    .power_down_o(power_down_o), .bus_o(bus_o), .port_o(port_o)
  );

  // ==========================================================================
  // compare and report
  task automatic check_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_vec(input string name, input logic [34:0] exp, input logic [34:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // bounded wait for the core to run; lo catches a release that comes too soon
  task automatic wait_run(input int lo, input int hi);
    int i;
    i = 0;
    while (core_run_o !== 1'b1) begin
      tick(1);
      i++;
      if (i > hi) begin
        miscompares++;
        $display("ERROR core_run_o expected 1 within %0d seen %b", hi, core_run_o);
        results();
      end
    end
    check_bit("release not early", 1'b1, i >= lo);
  endtask

  task automatic check_forced;
    check_bit("core_rst_n_o", 1'b0, core_rst_n_o);
    check_bit("pc_force_o", 1'b1, pc_force_o);
    check_vec("pc_value_o", 35'h0, {19'h0, pc_value_o});
    check_bit("phase first", 1'b1, phase_o == FIRST_PHASE);
    check_vec("bus_o", 35'h3, {32'h0, bus_o});
    check_vec("port_o", PORT_SAFE, port_o);
    check_bit("osc_buf_en_o", 1'b1, osc_buf_en_o);
  endtask

  task automatic check_running;
    tick(2);
    check_bit("core_rst_n_o", 1'b1, core_rst_n_o);
    check_bit("pc_force_o", 1'b0, pc_force_o);
    check_vec("bus_o", 35'h4, {32'h0, bus_o});
    check_vec("port_o", PORT_ALL, port_o);
  endtask

  task automatic go_sleep;
    sleep_req_i <= 1'b1;
    tick(1);
    sleep_req_i <= 1'b0;
    tick(1);
    check_bit("power_down_o", 1'b1, power_down_o);
    check_bit("osc_buf_en_o", 1'b0, osc_buf_en_o);
    tick(4);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_power_up;
    tick(8);
    check_forced();
    hold_low <= 1'b0;
    rst_n_i <= 1'b1;
    tick(1);
    wait_run(OSC_STARTUP_TIMER * DIV - 8, 60);
    check_running();
    $display("power-up test done");
  endtask

  task automatic t_master_clear_n;
    hold_low <= 1'b1;
    tick(2);
    check_forced();
    tick(30);
    check_bit("held in reset", 1'b0, core_rst_n_o);
    hold_low <= 1'b0;
    wait_run(0, 6);
    check_running();
    $display("master clear test done");
  endtask

  task automatic t_sleep;
    go_sleep();
    wake_irq_i <= 1'b1;
    tick(1);
    wake_irq_i <= 1'b0;
    tick(1);
    check_bit("power_down_o", 1'b0, power_down_o);
    check_bit("osc_buf_en_o", 1'b1, osc_buf_en_o);
    wait_run(OSC_STARTUP_TIMER * DIV - 8, 60);
    go_sleep();
    hold_low <= 1'b1;
    tick(2);
    check_forced();
    check_bit("power_down_o", 1'b0, power_down_o);
    hold_low <= 1'b0;
    wait_run(OSC_STARTUP_TIMER * DIV - 8, 60);
    check_running();
    $display("sleep test done");
  endtask

  task automatic t_por;
    por_event_i <= 1'b1;
    tick(1);
    por_event_i <= 1'b0;
    tick(1);
    check_forced();
    wait_run(POWER_UP_DELAY_TIMER - 4, 60);
    check_running();
    $display("power-on event test done");
  endtask

  task automatic t_wdt;
    wdt_tick_i <= 1'b1;
    tick(2000);
    wdt_tick_i <= 1'b0;
    hold_low <= 1'b1;
    tick(2);
    hold_low <= 1'b0;
    wait_run(0, 6);
    wdt_tick_i <= 1'b1;
    tick(65535);
    wdt_tick_i <= 1'b0;
    tick(4);
    check_bit("wdt_timeout_o", 1'b0, wdt_timeout_o);
    check_bit("core_run_o", 1'b1, core_run_o);
    wdt_tick_i <= 1'b1;
    tick(1);
    wdt_tick_i <= 1'b0;
    check_bit("wdt_timeout_o", 1'b1, wdt_timeout_o);
    tick(1);
    check_forced();
    wait_run(0, 6);
    check_running();
    $display("watchdog test done");
  endtask

  task automatic t_rc;
    osc_mode_i <= OSC_RC;
    osc_run <= 1'b0;
    rst_n_i <= 1'b0;
    tick(3);
    rst_n_i <= 1'b1;
    tick(1);
    wait_run(POWER_UP_DELAY_TIMER - 4, POWER_UP_DELAY_TIMER + 10);
    check_running();
    $display("rc mode test done");
  endtask

  initial begin
    t_power_up();
    t_master_clear_n();
    t_sleep();
    t_por();
    t_wdt();
    t_rc();
    results();
  end
endmodule
